// ### pse_pal_encoder.v
// PAL alternation, swinging burst gating and colour gate enables.
`timescale 1ns/1ns
`include "pse_defs.vh"
module pse_pal_encoder #(
  parameter BURST_CYC = `PSE_BURST_CYC
) (
  input  wire mclk,
  input  wire rst,
  input  wire sync_in,
  input  wire ball_in,
  input  wire left_bat_in,
  input  wire right_bat_in,
  input  wire playfield_in,
  output reg  pal_phase,
  output reg  pal_phase_n,
  output reg  burst_gate,
  output reg  burst_normal_en,
  output reg  burst_invert_en,
  output reg  red_normal_en,
  output reg  red_invert_en,
  output reg  green_normal_en,
  output reg  green_invert_en,
  output reg  blue_en,
  output reg  yellow_en,
  output reg  luma_white,
  output reg  luma_bright,
  output reg  luma_background
);

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  wire sync_s;
  wire ball_s;
  wire lbat_s;
  wire rbat_s;
  wire field_s;

  pse_sync2 u_sync (
    .mclk (mclk),
    .rst  (rst),
    .din  (sync_in),
    .dout (sync_s)
  );

  pse_sync2 u_ball (
    .mclk (mclk),
    .rst  (rst),
    .din  (ball_in),
    .dout (ball_s)
  );

  pse_sync2 u_lbat (
    .mclk (mclk),
    .rst  (rst),
    .din  (left_bat_in),
    .dout (lbat_s)
  );

  pse_sync2 u_rbat (
    .mclk (mclk),
    .rst  (rst),
    .din  (right_bat_in),
    .dout (rbat_s)
  );

  pse_sync2 u_field (
    .mclk (mclk),
    .rst  (rst),
    .din  (playfield_in),
    .dout (field_s)
  );

  // ------------------------------------------------------------
  // Sync trailing edge detection
  // ------------------------------------------------------------
  reg  sync_d;
  wire sync_trail;

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      sync_d <= 1'h0;
    end else begin
      sync_d <= sync_s;
    end
  end

  // A falling sync level marks the end of each line sync pulse.
  assign sync_trail = sync_d & ~sync_s;

  // ------------------------------------------------------------
  // Alternation flip-flop
  // ------------------------------------------------------------
  wire next_phase;

  assign next_phase = sync_trail ? ~pal_phase : pal_phase;

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      pal_phase <= `PSE_PHASE_RST;
    end else begin
      pal_phase <= next_phase;
    end
  end

  // The complement has its own flip-flop so both phase lines switch on the same edge.
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      pal_phase_n <= ~`PSE_PHASE_RST;
    end else begin
      pal_phase_n <= ~next_phase;
    end
  end

  // ------------------------------------------------------------
  // Burst gate pulse shaper
  // ------------------------------------------------------------
  reg [15:0] burst_cnt;
  reg [15:0] next_burst_cnt;
  reg        next_burst_gate;

  // A new trailing edge reloads the count, so a short line restarts the gate.
  always @* begin
    next_burst_cnt  = 16'h0000;
    next_burst_gate = 1'h0;
    if (sync_trail) begin
      next_burst_cnt  = BURST_CYC[15:0];
      next_burst_gate = 1'h1;
    end else if (burst_cnt > 16'h0001) begin
      next_burst_cnt  = burst_cnt - 16'h0001;
      next_burst_gate = 1'h1;
    end
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      burst_cnt  <= 16'h0000;
      burst_gate <= 1'h0;
    end else begin
      burst_cnt  <= next_burst_cnt;
      burst_gate <= next_burst_gate;
    end
  end

  // ------------------------------------------------------------
  // Colour gate enables
  // ------------------------------------------------------------
  wire background;
  wire ball_win;
  wire field_win;
  wire rbat_win;
  wire lbat_win;

  // Background is shown where no object is present and outside sync.
  assign background = ~ball_s & ~lbat_s & ~rbat_s & ~field_s & ~sync_s;

  // The ball covers everything, the playfield covers both bats and the right bat
  // covers the left one, so the blue/yellow group never opens with red or green.
  assign ball_win  = ball_s;
  assign field_win = field_s & ~ball_s;
  assign rbat_win  = rbat_s & ~ball_s & ~field_s;
  assign lbat_win  = lbat_s & ~ball_s & ~rbat_s & ~field_s;

  // ------------------------------------------------------------
  // Next values of the gate enables
  // ------------------------------------------------------------
  reg next_burst_normal_en;
  reg next_burst_invert_en;
  reg next_red_normal_en;
  reg next_red_invert_en;
  reg next_green_normal_en;
  reg next_green_invert_en;
  reg next_blue_en;
  reg next_yellow_en;
  reg next_luma_white;
  reg next_luma_bright;
  reg next_luma_background;

  always @* begin
    next_burst_normal_en = burst_gate & pal_phase;
    next_burst_invert_en = burst_gate & pal_phase_n;
    next_red_normal_en   = field_win & pal_phase;
    next_red_invert_en   = field_win & pal_phase_n;
    next_green_normal_en = background & pal_phase;
    next_green_invert_en = background & pal_phase_n;
    next_blue_en         = rbat_win;
    next_yellow_en       = lbat_win;
    next_luma_white      = ball_win;
    next_luma_bright     = field_s | lbat_s;
    next_luma_background = background;
  end

  // ------------------------------------------------------------
  // Burst phase gate enables
  // ------------------------------------------------------------
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      burst_normal_en <= 1'h0;
    end else begin
      burst_normal_en <= next_burst_normal_en;
    end
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      burst_invert_en <= 1'h0;
    end else begin
      burst_invert_en <= next_burst_invert_en;
    end
  end

  // ------------------------------------------------------------
  // Red and green gate enables
  // ------------------------------------------------------------
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      red_normal_en <= 1'h0;
    end else begin
      red_normal_en <= next_red_normal_en;
    end
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      red_invert_en <= 1'h0;
    end else begin
      red_invert_en <= next_red_invert_en;
    end
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      green_normal_en <= 1'h0;
    end else begin
      green_normal_en <= next_green_normal_en;
    end
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      green_invert_en <= 1'h0;
    end else begin
      green_invert_en <= next_green_invert_en;
    end
  end

  // ------------------------------------------------------------
  // Blue and yellow gate enables
  // ------------------------------------------------------------
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      blue_en <= 1'h0;
    end else begin
      blue_en <= next_blue_en;
    end
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      yellow_en <= 1'h0;
    end else begin
      yellow_en <= next_yellow_en;
    end
  end

  // ------------------------------------------------------------
  // Luminance enables
  // ------------------------------------------------------------
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      luma_white <= 1'h0;
    end else begin
      luma_white <= next_luma_white;
    end
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      luma_bright <= 1'h0;
    end else begin
      luma_bright <= next_luma_bright;
    end
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      luma_background <= 1'h0;
    end else begin
      luma_background <= next_luma_background;
    end
  end
endmodule // pse_pal_encoder

// ### pse_defs.vh
// Constants for the PAL switch, burst and colour enable block.
// What this block does
// - Toggle flip-flop divides line rate by two, swapping alternation phase every line.
// - True output enables normal lines, complement output enables inverted-phase lines.
// - Second flip-flop shapes a sync trailing-edge pulse into a clean burst gate.
// - Two AND gates steer burst gate to exactly one burst phase gate per line.
// - Four AND gates form red and green enables from phase and object enables.
// - Alternation phase selects which red/green gate pair conducts on each line.
// - Blue/yellow switches never open with red/green ones; burst can open together with the green background gate.
// - Green background enable is an AND of game outputs; the same term drives luma_background.
// - Playfield and left bat luminance merge through an OR for equal level.
// - Ball white, background green, left bat yellow, right bat blue, playfield red.
`ifndef PSE_DEFS_VH
`define PSE_DEFS_VH
`define PSE_CLK_HZ        50000000
`define PSE_LINE_HZ       15625
`define PSE_ALT_HZ        7800
`define PSE_BURST_NS      2250
`define PSE_BURST_CYC     ((`PSE_BURST_NS * (`PSE_CLK_HZ / 1000000)) / 1000)
`define PSE_PHASE_RST     1'h0
`endif

// ### pse_sync2.v
// Two flip-flop synchroniser for one pin input.
`timescale 1ns/1ns
module pse_sync2 (
  input  wire mclk,
  input  wire rst,
  input  wire din,
  output reg  dout
);
  reg meta;

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      meta <= 1'h0;
      dout <= 1'h0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule // pse_sync2

// ### pse_game_model.sv
// Game chip model sending one sync pulse per line.
`timescale 1ns/1ns
module pse_game_model (
  input  logic mclk,
  input  logic run,
  output logic sync_in = 1'h0
);
  int n = 0;
  always @(posedge mclk) begin
    n <= run && n < 199 ? n + 1 : 0;
    sync_in <= run && n < 15;
  end
endmodule // pse_game_model

// ### pse_pal_encoder_assertions.sv
// Checker for the alternation and burst outputs.
`timescale 1ns/1ns
module pse_pal_encoder_chk #(parameter int BURST_CYC = 112) (
  input logic mclk,
  input logic rst,
  input logic pal_phase,
  input logic pal_phase_n,
  input logic burst_gate,
  input logic burst_normal_en,
  input logic burst_invert_en,
  input logic blue_en,
  input logic yellow_en
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_phase_pair: assert property (pal_phase_n == !pal_phase)
    else $error("phase pair");
  a_one_burst: assert property (!(burst_normal_en && burst_invert_en))
    else $error("two bursts");
  a_burst_len: assert property ($rose(burst_gate) |-> ##BURST_CYC !burst_gate)
    else $error("burst length");
  a_toggle_burst: assert property ($changed(pal_phase) |-> burst_gate)
    else $error("toggle without burst");
  a_burst_side: assert property (burst_normal_en || burst_invert_en |-> burst_normal_en == pal_phase)
    else $error("burst side");
  a_burst_cause: assert property (burst_normal_en || burst_invert_en |-> $past(burst_gate))
    else $error("burst cause");
  a_phase_steady: assert property (burst_gate && $past(burst_gate) |-> $stable(pal_phase))
    else $error("phase moved");
  a_blue_yellow: assert property (!(blue_en && yellow_en))
    else $error("blue and yellow");
endmodule // pse_pal_encoder_chk

bind pse_pal_encoder pse_pal_encoder_chk #(.BURST_CYC(BURST_CYC)) u_pse_pal_encoder_chk (
  .mclk(mclk), .rst(rst), .pal_phase(pal_phase), .pal_phase_n(pal_phase_n),
  .burst_gate(burst_gate), .burst_normal_en(burst_normal_en),
  .burst_invert_en(burst_invert_en), .blue_en(blue_en), .yellow_en(yellow_en));

// ### test_pse_pal_encoder.sv
// Bench for the PAL alternation, burst and colour enables.
`timescale 1ns/1ns
module test_pse_pal_encoder;
  logic       mclk = 1'h0, rst = 1'h1, run = 1'h0, ep = 1'h0, ph, phn, bg, sync_in;
  logic [1:0] b;
  logic [3:0] obj = 4'h0;
  logic [8:0] o;
  int         err_count = 0, cmp_count = 0, cyc = 0;
  always #10 mclk = !mclk;
  pse_game_model u_pse_game_model (.mclk(mclk), .run(run), .sync_in(sync_in));
  pse_pal_encoder #(.BURST_CYC(20)) u_pse_pal_encoder (.mclk(mclk), .rst(rst),
    .sync_in(sync_in), .ball_in(obj[3]), .left_bat_in(obj[2]), .right_bat_in(obj[1]),
    .playfield_in(obj[0]), .pal_phase(ph), .pal_phase_n(phn), .burst_gate(bg),
    .burst_normal_en(b[1]), .burst_invert_en(b[0]), .luma_white(o[8]), .luma_bright(o[7]),
    .luma_background(o[6]), .blue_en(o[5]), .yellow_en(o[4]), .red_normal_en(o[3]),
    .red_invert_en(o[2]), .green_normal_en(o[1]), .green_invert_en(o[0]));
  task automatic chk(string nm, logic [8:0] e, logic [8:0] g);
    cmp_count++;
    if (e !== g) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Each row holds ball, left, right, playfield, then the expected colour outputs.
  task automatic t_colour;
    logic [10:0] t [6] = '{11'h011, 11'h440, 11'h224, 11'h108, 11'h0a2, 11'h328};
    foreach (t[i]) begin
      @(posedge mclk) obj <= t[i][10:7];
      repeat (4) @(posedge mclk);
      #1 chk("colour", {t[i][6:2], t[i][1] & ep, t[i][1] & !ep, t[i][0] & ep, t[i][0] & !ep}, o);
    end
  endtask
  task automatic t_lines(int n);
    int k;
    @(posedge mclk) run <= 1'h1;
    repeat (n) begin
      k = 0;
      while (bg !== 1'h1 && k < 400) begin
        @(posedge mclk);
        #1 k++;
      end
      ep = !ep;
      chk("phase", {ep, !ep}, {ph, phn});
      @(posedge mclk);
      #1 chk("burst", {ep, !ep}, b);
      repeat (40) @(posedge mclk);
    end
    run <= 1'h0;
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      report_and_stop;
    end
  end
  initial begin
    repeat (5) @(posedge mclk);
    #1 chk("reset", 9'h008, {ph, phn, b, bg});
    chk("reset", 9'h000, o);
    @(posedge mclk) rst <= 1'h0;
    t_colour;
    t_lines(3);
    t_colour;
    t_lines(2);
    report_and_stop;
  end
endmodule // test_pse_pal_encoder
